// ---- core/pmrf_map.vh ----
// pmrf_map.vh: register offsets, field positions, reset values and timing
// counts of the power monitor register file. definitions only.
`ifndef PMRF_MAP_VH
`define PMRF_MAP_VH

// ==========================================================================
// register locations (low three pointer bits only)
`define PMRF_LOC_CUR_HI 3'h0
`define PMRF_LOC_CUR_LO 3'h1
`define PMRF_LOC_SUP_HI 3'h2
`define PMRF_LOC_SUP_LO 3'h3
`define PMRF_LOC_AUX_HI 3'h4
`define PMRF_LOC_AUX_LO 3'h5
`define PMRF_LOC_CTRL 3'h6
`define PMRF_LOC_RSVD 3'h7
`define PMRF_PTR_ZERO 3'h0
`define PMRF_PTR_ONE 3'h1

// ==========================================================================
// control register fields
`define PMRF_CTRL_SNAP 7
`define PMRF_CTRL_SEL_HI 6
`define PMRF_CTRL_SEL_LO 5
`define PMRF_CTRL_TEST 4
`define PMRF_CTRL_PAGE 3
`define PMRF_CTRL_TMO 2
`define PMRF_CTRL_WMASK 8'hfc
`define PMRF_CTRL_RESET 8'h0c

// ==========================================================================
// low result byte fields and channel codes
`define PMRF_LO_BUSY 3
`define PMRF_LO_DATA_MASK 8'hf0
`define PMRF_ZERO_BYTE 8'h00
`define PMRF_ZERO_RESULT 12'h000
`define PMRF_CH_CUR 2'h0
`define PMRF_CH_SUP 2'h1
`define PMRF_CH_AUX 2'h2
`define PMRF_CH_NONE 2'h3

// ==========================================================================
// stuck-bus timeout: 33 ms at 250 MHz
`define PMRF_TMO_MS 33
`define PMRF_CLK_KHZ 250000
`define PMRF_TMO_CYCLES (`PMRF_TMO_MS * `PMRF_CLK_KHZ)

`endif

// ---- core/pmrf_bus_timer.v ----
// pmrf_bus_timer.v: stuck-bus timer for the serial interface.
// assumes scl/sda levels are synchronous to i_core_clk.
`timescale 1ns/1ns
`include "pmrf_map.vh"

module pmrf_bus_timer #(
   parameter TMO_CYCLES = `PMRF_TMO_CYCLES, // cycles of low before expiry
   parameter CNT_W = 24 // counter width, must hold TMO_CYCLES
) (
   // clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // bus levels and enable
   input wire i_scl,
   input wire i_sda,
   input wire i_enable,
   // expiry pulse
   output reg o_expire
);

   reg [CNT_W-1:0] low_cnt_ff; // cycles either line has been low
   wire bus_low = ~i_scl | ~i_sda; // lows are or'ed
   wire [CNT_W-1:0] tmo_lim = TMO_CYCLES[CNT_W-1:0];

   // ========================================================================
   // counter: runs while low, clears when both high or disabled
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         low_cnt_ff <= {CNT_W{1'b0}};
         o_expire <= 1'b0;
      end else if (!i_enable || !bus_low) begin // R15 R16
         low_cnt_ff <= {CNT_W{1'b0}};
         o_expire <= 1'b0;
      end else if (low_cnt_ff == tmo_lim) begin
         // one pulse, then hold: a bus stuck for good resets once
         low_cnt_ff <= low_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1}; // R16
         o_expire <= 1'b1;
      end else begin
         if (low_cnt_ff < tmo_lim)
            low_cnt_ff <= low_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
         o_expire <= 1'b0;
      end
   end

endmodule // pmrf_bus_timer

// ---- core/pmrf_conv_seq.v ----
// pmrf_conv_seq.v: sequences converter channel requests.
// assumes the converter answers each start with one done pulse.
`timescale 1ns/1ns
`include "pmrf_map.vh"

module pmrf_conv_seq (
   // clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // mode from control register
   input wire i_snap,
   input wire [1:0] i_sel,
   input wire i_test,
   input wire i_snap_go,
   // converter handshake
   input wire i_conv_done,
   // sequencer outputs
   output reg o_start,
   output reg [1:0] o_chan,
   output reg o_busy
);

   localparam ST_IDLE = 2'b00; // halted
   localparam ST_CONV = 2'b01; // conversion in flight
   reg [1:0] state_ff;

   // ========================================================================
   // free run scans current, supply, aux; snapshot does one channel
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= ST_IDLE;
         o_start <= 1'b0;
         o_chan <= `PMRF_CH_CUR;
         o_busy <= 1'b0;
      end else begin
         o_start <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (i_test) begin // R12
                  o_busy <= 1'b0;
               end else if (i_snap_go && i_sel != `PMRF_CH_NONE) begin // R8 R11
                  o_chan <= i_sel;
                  o_start <= 1'b1;
                  o_busy <= 1'b1;
                  state_ff <= ST_CONV;
               end else if (!i_snap) begin // R9
                  o_start <= 1'b1;
                  state_ff <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (i_conv_done) begin
                  o_busy <= 1'b0; // R8
                  state_ff <= ST_IDLE;
                  if (!i_snap)
                     o_chan <= (o_chan == `PMRF_CH_AUX) ? `PMRF_CH_CUR :
                               o_chan + 2'h1; // R9
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

endmodule // pmrf_conv_seq

// ---- core/pmrf_regfile.v ----
// pmrf_regfile.v: register file of the power monitor.
// How it works
// R1: pointer uses only low three address bits
// R2: result writes accepted only in test mode
// R3: current result: high byte, upper low nibble
// R4: supply result: same split, 25 mV counts
// R5: aux result: same split, 500 uV counts
// R6: low byte bit 3 shows snapshot busy
// R7: reserved bits read zero, writes dropped
// R8: snapshot converts selected channel, then halts
// R9: snapshot clear means continuous scanning
// R10: control bits 6:5 select channel, 00 current
// R11: 01 supply, 10 aux, 11 unused
// R12: test mode halts converter, resets clear
// R13: page bit 3 enables auto-increment, resets one
// R14: page disabled keeps pointer fixed
// R15: timer enable bit 2, resets one
// R16: low over 33 ms resets serial engine
// R17: command byte loads pointer, data increments
// R18: stop returns pointer to zero
// R19: read acknowledge advances to next location
// assumes the serial engine gives one-cycle strobes synchronous to the clock.
`timescale 1ns/1ns
`include "pmrf_map.vh"

module pmrf_regfile #(
   parameter TMO_CYCLES = `PMRF_TMO_CYCLES, // stuck-bus timeout in cycles
   parameter RES_W = 12 // result width
) (
   // clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // serial engine strobes
   input wire i_cmd_wr,
   input wire [7:0] i_cmd_byte,
   input wire i_data_wr,
   input wire [7:0] i_wr_data,
   input wire i_data_rd,
   input wire i_stop,
   // bus line levels for the stuck timer
   input wire i_scl,
   input wire i_sda,
   // converter side
   input wire i_conv_done,
   input wire [1:0] i_conv_chan,
   input wire [RES_W-1:0] i_conv_result,
   // read data and pointer
   output reg [7:0] o_rd_data,
   output reg [2:0] o_ptr,
   // serial engine reset
   output reg o_bus_reset,
   // converter control
   output reg o_conv_start,
   output reg [1:0] o_conv_chan,
   output reg o_conv_halt,
   // control bits
   output reg [7:0] o_ctrl
);

   // ========================================================================
   // storage
   reg [RES_W-1:0] res_ff [0:2]; // current, supply, aux results
   reg [2:0] busy_ff; // per channel snapshot busy
   reg [7:0] ctrl_ff;
   reg [2:0] ptr_ff;
   reg snap_go_ff; // request one snapshot
   reg [7:0] nxt_rd;
   wire seq_start;
   wire [1:0] seq_chan;
   wire seq_busy;
   wire tmo_expire;
   wire test_on = ctrl_ff[`PMRF_CTRL_TEST];
   wire page_on = ctrl_ff[`PMRF_CTRL_PAGE];
   wire [1:0] sel = {ctrl_ff[`PMRF_CTRL_SEL_HI], ctrl_ff[`PMRF_CTRL_SEL_LO]};

   // byte of a location: pairs of locations form a channel
   function [7:0] loc_byte;
      input [2:0] loc;
      input [RES_W-1:0] res;
      input busy;
      begin
         if (loc[0] == 1'b0)
            loc_byte = res[RES_W-1:4]; // R3 R4 R5
         else
            loc_byte = {res[3:0], busy, 3'b000}; // R6 R7
      end
   endfunction

   // ========================================================================
   // sub blocks
   pmrf_conv_seq u_seq (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_snap(ctrl_ff[`PMRF_CTRL_SNAP]),
      .i_sel(sel),
      .i_test(test_on),
      .i_snap_go(snap_go_ff),
      .i_conv_done(i_conv_done),
      .o_start(seq_start),
      .o_chan(seq_chan),
      .o_busy(seq_busy)
   );

   pmrf_bus_timer #(
      .TMO_CYCLES(TMO_CYCLES)
   ) u_tmr (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .i_enable(ctrl_ff[`PMRF_CTRL_TMO]),
      .o_expire(tmo_expire)
   );

   // ========================================================================
   // address pointer
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ptr_ff <= `PMRF_PTR_ZERO;
      end else if (i_stop || tmo_expire) begin
         ptr_ff <= `PMRF_PTR_ZERO; // R18
      end else if (i_cmd_wr) begin
         ptr_ff <= i_cmd_byte[2:0]; // R1 R17
      end else if ((i_data_wr || i_data_rd) && page_on) begin
         ptr_ff <= ptr_ff + `PMRF_PTR_ONE; // R13 R17 R19
      end
      // page off: pointer stays put R14
   end

   // ========================================================================
   // control register and snapshot trigger
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_ff <= `PMRF_CTRL_RESET; // R9 R10 R12 R13 R15
         snap_go_ff <= 1'b0;
      end else begin
         if (i_data_wr && ptr_ff == `PMRF_LOC_CTRL) begin
            ctrl_ff <= i_wr_data & `PMRF_CTRL_WMASK; // R7
            // writing with snapshot set starts one conversion
            snap_go_ff <= i_wr_data[`PMRF_CTRL_SNAP]; // R8
         end else if (seq_start && seq_busy) begin
            // request stays pending until the sequencer takes it, so a
            // write that lands mid free-run conversion is not lost
            snap_go_ff <= 1'b0; // R8
         end
      end
   end

   // ========================================================================
   // results and busy flags; host write in test mode beats converter
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_chan
         always @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
               res_ff[g] <= `PMRF_ZERO_RESULT;
               busy_ff[g] <= 1'b0;
            end else begin
               if (test_on && i_data_wr && ptr_ff[2:1] == g) begin // R2
                  if (ptr_ff[0] == 1'b0)
                     res_ff[g][RES_W-1:4] <= i_wr_data; // R3
                  else
                     res_ff[g][3:0] <= i_wr_data[7:4]; // R6 R7
               end else if (i_conv_done && !test_on &&
                            i_conv_chan == g) begin
                  res_ff[g] <= i_conv_result;
               end
               // busy tracks the sequencer's snapshot channel
               if (seq_start && seq_busy == 1'b0 && seq_chan == g &&
                   ctrl_ff[`PMRF_CTRL_SNAP])
                  busy_ff[g] <= 1'b1; // R6
               else if (snap_go_ff && sel == g)
                  busy_ff[g] <= 1'b1; // R6
               else if (i_conv_done && i_conv_chan == g)
                  busy_ff[g] <= 1'b0; // R8
               else if (test_on)
                  busy_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ========================================================================
   // read mux
   always @* begin
      case (ptr_ff)
         `PMRF_LOC_CUR_HI, `PMRF_LOC_CUR_LO:
            nxt_rd = loc_byte(ptr_ff, res_ff[0], busy_ff[0]);
         `PMRF_LOC_SUP_HI, `PMRF_LOC_SUP_LO:
            nxt_rd = loc_byte(ptr_ff, res_ff[1], busy_ff[1]);
         `PMRF_LOC_AUX_HI, `PMRF_LOC_AUX_LO:
            nxt_rd = loc_byte(ptr_ff, res_ff[2], busy_ff[2]);
         `PMRF_LOC_CTRL: nxt_rd = ctrl_ff; // R7
         default: nxt_rd = `PMRF_ZERO_BYTE; // reserved location
      endcase
   end

   // ========================================================================
   // registered outputs
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= `PMRF_ZERO_BYTE;
         o_ptr <= `PMRF_PTR_ZERO;
         o_bus_reset <= 1'b0;
         o_conv_start <= 1'b0;
         o_conv_chan <= `PMRF_CH_CUR;
         o_conv_halt <= 1'b0;
         o_ctrl <= `PMRF_CTRL_RESET;
      end else begin
         o_rd_data <= nxt_rd;
         o_ptr <= ptr_ff;
         o_bus_reset <= tmo_expire; // R16
         o_conv_start <= seq_start & ~test_on;
         o_conv_chan <= seq_chan;
         // halt in test mode, or in snapshot mode when idle
         o_conv_halt <= test_on | (ctrl_ff[`PMRF_CTRL_SNAP] & ~seq_busy); // R12
         o_ctrl <= ctrl_ff;
      end
   end

endmodule // pmrf_regfile

// ---- test/pmrf_regfile_props.sv ----
// pmrf_regfile_props.sv: port assertions for the register file.
// assumes a bind onto pmrf_regfile, one clock, async high reset.
`timescale 1ns/1ns
module pmrf_regfile_props #(
   parameter TMO_CYCLES = 20 // stuck-bus limit in cycles
) (
   // clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // serial engine side
   input wire i_cmd_wr,
   input wire [7:0] i_cmd_byte,
   input wire i_data_wr,
   input wire i_data_rd,
   input wire i_stop,
   input wire i_scl,
   input wire i_sda,
   // observed outputs
   input wire [2:0] o_ptr,
   input wire o_bus_reset,
   input wire o_conv_start,
   input wire [1:0] o_conv_chan,
   input wire o_conv_halt,
   input wire [7:0] o_ctrl
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   // ======================================================================
   // helper: length of the current low run on either bus line
   reg [31:0] low_cnt_ff;
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         low_cnt_ff <= 32'h0000_0000;
      else if (i_scl && i_sda)
         low_cnt_ff <= 32'h0000_0000;
      else
         low_cnt_ff <= low_cnt_ff + 32'h0000_0001;
   end

   // ======================================================================
   // assertions
   chk_ctrl_rsvd: assert property (o_ctrl[1:0] == 2'h0)
      else $error("control low bits not zero");
   chk_cmd_ptr: assert property (i_cmd_wr && !i_stop
      |-> ##2 o_ptr == $past(i_cmd_byte[2:0], 2))
      else $error("pointer not loaded from command");
   chk_stop_ptr: assert property (i_stop |-> ##2 o_ptr == 3'h0)
      else $error("pointer not cleared by stop");
   chk_ptr_step: assert property ((i_data_rd || i_data_wr)
      && !i_stop && !i_cmd_wr
      |-> ##2 o_ptr == $past(o_ptr) + {2'h0, $past(o_ctrl[3])})
      else $error("pointer step wrong");
   chk_test_halt: assert property (o_ctrl[4] && $past(o_ctrl[4], 3)
      |-> o_conv_halt && !o_conv_start)
      else $error("converter active in test mode");
   chk_snap_chan: assert property (o_conv_start && o_ctrl[7]
      && $past(o_ctrl[7], 4) |-> o_conv_chan == o_ctrl[6:5])
      else $error("snapshot channel wrong");
   chk_no_unused: assert property (o_conv_start |-> o_conv_chan != 2'h3)
      else $error("unused channel started");
   chk_tmo_off: assert property (!o_ctrl[2] && !$past(o_ctrl[2], 2)
      |-> !o_bus_reset)
      else $error("bus reset while timer off");
   chk_tmo_early: assert property (o_bus_reset
      |-> low_cnt_ff >= TMO_CYCLES)
      else $error("bus reset too early");
   chk_tmo_fire: assert property (low_cnt_ff == TMO_CYCLES + 1
      && o_ctrl[2] && $past(o_ctrl[2], 8) |-> ##[0:4] o_bus_reset)
      else $error("bus reset missing");
endmodule // pmrf_regfile_props

// ---- test/pmrf_conv_model.sv ----
// pmrf_conv_model.sv: converter stand-in answering each start pulse.
// assumes one start at a time; results depend on the channel only.
`timescale 1ns/1ns
module pmrf_conv_model #(
   parameter [7:0] DLY = 8'h14 // cycles from start to done
) (
   // clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // request from the register file
   input wire i_start,
   input wire [1:0] i_chan,
   // answer
   output reg o_done,
   output wire [1:0] o_chan,
   output wire [11:0] o_result
);
   reg [7:0] cnt_ff;
   reg [1:0] chan_ff;
   reg [11:0] res_ff;
   // outside the done pulse the lines show the inverse, never stale data
   assign o_chan = o_done ? chan_ff : ~chan_ff;
   assign o_result = o_done ? res_ff : ~res_ff;
   // ======================================================================
   // countdown then a one-cycle done pulse
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_ff <= 8'h00;
         chan_ff <= 2'h0;
         res_ff <= 12'h000;
         o_done <= 1'b0;
      end else begin
         o_done <= (cnt_ff == 8'h01);
         if (i_start) begin
            cnt_ff <= DLY;
            chan_ff <= i_chan;
            res_ff <= 12'h9c3 + 12'h111 * {10'h000, i_chan};
         end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end
endmodule // pmrf_conv_model

// ---- test/power_monitor_register_file_test.sv ----
// power_monitor_register_file_test.sv: bench for the register file.
// assumes the converter model and the props checker are compiled first.
`timescale 1ns/1ns
module power_monitor_register_file_test;
   // ======================================================================
   // stimulus and observed signals
   reg i_core_clk = 1'b0;
   reg i_rst = 1'b1;
   reg i_cmd_wr = 1'b0;
   reg [7:0] i_cmd_byte = 8'h00;
   reg i_data_wr = 1'b0;
   reg [7:0] i_wr_data = 8'h00;
   reg i_data_rd = 1'b0;
   reg i_stop = 1'b0;
   reg i_scl = 1'b1;
   reg i_sda = 1'b1;
   wire i_conv_done;
   wire [1:0] i_conv_chan;
   wire [11:0] i_conv_result;
   wire [7:0] o_rd_data;
   wire [2:0] o_ptr;
   wire o_bus_reset;
   wire o_conv_start;
   wire [1:0] o_conv_chan;
   wire o_conv_halt;
   wire [7:0] o_ctrl;
   integer err_total = 0;
   integer checks = 0;
   integer cyc = 0;
   integer i;
   integer n;
   reg [11:0] r;
   always #2 i_core_clk = ~i_core_clk;

   pmrf_regfile #(.TMO_CYCLES(20)) pmrf_regfile_inst (.i_core_clk,
      .i_rst, .i_cmd_wr, .i_cmd_byte, .i_data_wr, .i_wr_data, .i_data_rd,
      .i_stop, .i_scl, .i_sda, .i_conv_done, .i_conv_chan, .i_conv_result,
      .o_rd_data, .o_ptr, .o_bus_reset, .o_conv_start, .o_conv_chan,
      .o_conv_halt, .o_ctrl);
   pmrf_conv_model pmrf_conv_model_inst (.i_core_clk, .i_rst,
      .i_start(o_conv_start), .i_chan(o_conv_chan), .o_done(i_conv_done),
      .o_chan(i_conv_chan), .o_result(i_conv_result));

   // ======================================================================
   // tasks
   task stop_test;
      begin
         if (err_total == 0 && checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task cmp(input [7:0] got, input [7:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
         end
      end
   endtask
   // k: 0 command byte, 1 data byte, 2 stop
   task strobe(input [1:0] k, input [7:0] b);
      begin
         @(negedge i_core_clk);
         i_cmd_byte = b;
         i_wr_data = b;
         i_cmd_wr = (k == 2'h0);
         i_data_wr = (k == 2'h1);
         i_stop = (k == 2'h2);
         @(negedge i_core_clk);
         {i_cmd_wr, i_data_wr, i_stop} = 3'h0;
      end
   endtask
   task wreg(input [7:0] loc, input [7:0] val);
      begin
         strobe(2'h0, loc);
         strobe(2'h1, val);
         strobe(2'h2, 8'h00);
      end
   endtask
   // compare the byte shown, then acknowledge it to move on
   task read_chk(input [7:0] exp);
      begin
         @(negedge i_core_clk);
         cmp(o_rd_data, exp);
         i_data_rd = 1'b1;
         @(negedge i_core_clk);
         i_data_rd = 1'b0;
      end
   endtask
   function [11:0] res(input [1:0] c);
      res = 12'h9c3 + 12'h111 * {10'h000, c};
   endfunction

   // ======================================================================
   // hang guard: the whole sequence needs well under 2000 cycles
   always @(posedge i_core_clk) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         err_total = err_total + 1;
         stop_test;
      end
   end

   // ======================================================================
   // main sequence
   initial begin
      repeat (2) @(negedge i_core_clk);
      i_rst = 1'b0;
      repeat (80) @(negedge i_core_clk);
      strobe(2'h0, 8'h00);
      for (i = 0; i < 3; i = i + 1) begin
         r = res(i[1:0]);
         read_chk(r[11:4]);
         read_chk({r[3:0], 4'h0});
      end
      read_chk(8'h0c);
      read_chk(8'h00);
      strobe(2'h0, 8'hfb);
      read_chk(8'h40);
      wreg(8'h06, 8'hef);
      repeat (40) @(negedge i_core_clk);
      wreg(8'h02, 8'h55);
      wreg(8'h07, 8'hff);
      strobe(2'h0, 8'h02);
      read_chk(8'had);
      strobe(2'h0, 8'h06);
      read_chk(8'hec);
      read_chk(8'h00);
      wreg(8'h06, 8'h1f);
      strobe(2'h0, 8'h00);
      strobe(2'h1, 8'h12);
      strobe(2'h1, 8'hff);
      strobe(2'h1, 8'h34);
      strobe(2'h2, 8'h00);
      strobe(2'h0, 8'h00);
      read_chk(8'h12);
      read_chk(8'hf0);
      read_chk(8'h34);
      wreg(8'h06, 8'he4);
      strobe(2'h0, 8'h06);
      read_chk(8'he4);
      read_chk(8'he4);
      strobe(2'h0, 8'h05);
      strobe(2'h2, 8'h00);
      read_chk(8'h12);
      strobe(2'h0, 8'h06);
      n = 0;
      i_scl = 1'b0;
      repeat (40) begin
         @(negedge i_core_clk);
         if (o_bus_reset === 1'b1)
            n = n + 1;
      end
      i_scl = 1'b1;
      cmp((n != 0) ? 8'h01 : 8'h00, 8'h01);
      read_chk(8'h12);
      wreg(8'h06, 8'he0);
      n = 0;
      i_sda = 1'b0;
      repeat (40) begin
         @(negedge i_core_clk);
         if (o_bus_reset !== 1'b0)
            n = n + 1;
      end
      i_sda = 1'b1;
      cmp((n != 0) ? 8'h01 : 8'h00, 8'h00);
      for (i = 0; i < 3; i = i + 1) begin
         r = res(i[1:0]);
         wreg(8'h06, {1'b1, i[1:0], 5'h0c});
         strobe(2'h0, {5'h00, i[1:0], 1'b1});
         // while busy the old nibble stands; current low was written f
         read_chk({(i == 0) ? 4'hf : r[3:0], 4'h8});
         repeat (40) @(negedge i_core_clk);
         strobe(2'h0, {5'h00, i[1:0], 1'b1});
         read_chk({r[3:0], 4'h0});
         cmp({7'h00, o_conv_halt}, 8'h01);
      end
      stop_test;
   end
endmodule // power_monitor_register_file_test

bind pmrf_regfile pmrf_regfile_props #(.TMO_CYCLES(TMO_CYCLES))
   pmrf_regfile_props_inst (.i_core_clk, .i_rst, .i_cmd_wr, .i_cmd_byte,
   .i_data_wr, .i_data_rd, .i_stop, .i_scl, .i_sda, .o_ptr, .o_bus_reset,
   .o_conv_start, .o_conv_chan, .o_conv_halt, .o_ctrl);
